// ### design/bpe_buck_ctrl.sv
// Register bank, pin enable and alternate voltage selection for one buck regulator
`timescale 1ns/1ps
module bpe_buck_ctrl
   import bpe_pkg::*;
(
   input  wire logic                   mclk,
   input  wire logic                   rst,
   input  wire logic [BPE_ADDR_W-1:0]  reg_addr,
   input  wire logic [BPE_DATA_W-1:0]  reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic      [BPE_DATA_W-1:0]  reg_rdata,
   output logic                        reg_ack,
   input  wire logic [BPE_PIN_N-1:0]   multipurpose_control_pin,
   input  wire logic [1:0]             dvs_pin_state,
   input  wire logic [BPE_SEQ_W-1:0]   regulator_sequence_field,
   input  wire logic [BPE_EN_W-1:0]    regulator_enable_field,
   input  wire logic [BPE_CODE_W-1:0]  serial_voltage_code,
   output logic                        pin_control_active,
   output logic                        regulator_pin_enable,
   output logic      [BPE_CODE_W-1:0]  target_voltage_code,
   output logic      [BPE_CFG_W-1:0]   dvs_config_field
);

   logic [BPE_PIN_N-1:0]  pin_enable_select;
   logic [BPE_CODE_W-1:0] alt_voltage_code [BPE_ALT_N];
   logic [BPE_ALT_N-1:0]  alt_wr;
   logic                  pin_sel_wr;
   logic                  cfg_wr;
   logic                  gate_active;
   logic                  gate_enable;

   logic [BPE_CODE_W-1:0] readback_reg;
   logic [BPE_CODE_W-1:0] readback_next;
   logic [BPE_DATA_W-1:0] rdata_reg;
   logic [BPE_DATA_W-1:0] rdata_next;
   logic                  ack_reg;
   logic                  ack_next;
   logic                  active_reg;
   logic                  active_next;
   logic                  pin_en_reg;
   logic                  pin_en_next;
   logic [BPE_CODE_W-1:0] target_reg;
   logic [BPE_CODE_W-1:0] target_next;

   // Write strobes; a simultaneous read and write is taken as a write
   assign pin_sel_wr = reg_wr && (reg_addr == BPE_OFS_PIN_SELECT);
   assign cfg_wr     = reg_wr && (reg_addr == BPE_OFS_DVS_CONFIG);
   assign alt_wr[0]  = reg_wr && (reg_addr == BPE_OFS_ALT_VOLT_0);
   assign alt_wr[1]  = reg_wr && (reg_addr == BPE_OFS_ALT_VOLT_1);
   assign alt_wr[2]  = reg_wr && (reg_addr == BPE_OFS_ALT_VOLT_2);
   assign alt_wr[3]  = reg_wr && (reg_addr == BPE_OFS_ALT_VOLT_3);

   // Only the low field bits are stored, so upper bits can never hold a value
   bpe_field_reg #(
      .W         (BPE_PIN_N),
      .RST_VALUE (BPE_RST_PIN_SELECT)
   ) u_pin_select (
      .mclk  (mclk),
      .rst   (rst),
      .wr_en (pin_sel_wr),
      .wdata (reg_wdata[BPE_PIN_N-1:0]),
      .q     (pin_enable_select)
   );

   bpe_field_reg #(
      .W         (BPE_CFG_W),
      .RST_VALUE (BPE_RST_DVS_CONFIG)
   ) u_dvs_config (
      .mclk  (mclk),
      .rst   (rst),
      .wr_en (cfg_wr),
      .wdata (reg_wdata[BPE_CFG_W-1:0]),
      .q     (dvs_config_field)
   );

   generate
      for (genvar i = 0; i < BPE_ALT_N; i++)
      begin : g_alt
         bpe_field_reg #(
            .W         (BPE_CODE_W),
            .RST_VALUE (BPE_RST_ALT_VOLT)
         ) u_alt (
            .mclk  (mclk),
            .rst   (rst),
            .wr_en (alt_wr[i]),
            .wdata (reg_wdata[BPE_CODE_W-1:0]),
            .q     (alt_voltage_code[i])
         );
      end
   endgenerate

   bpe_pin_enable u_pin_enable (
      .pin_select (pin_enable_select),
      .pin_level  (multipurpose_control_pin),
      .seq_field  (regulator_sequence_field),
      .en_field   (regulator_enable_field),
      .active     (gate_active),
      .enable     (gate_enable)
   );

   always_comb
   begin
      active_next   = gate_active;
      pin_en_next   = gate_enable;
      readback_next = serial_voltage_code;
      target_next   = alt_voltage_code[0];
      unique case (dvs_pin_state)
         2'h0: target_next = alt_voltage_code[0];
         2'h1: target_next = alt_voltage_code[1];
         2'h2: target_next = alt_voltage_code[2];
         2'h3: target_next = alt_voltage_code[3];
      endcase
   end

   // Read data held until the next read so a slow host can sample it late
   always_comb
   begin
      ack_next   = reg_wr || reg_rd;
      rdata_next = rdata_reg;
      if (reg_rd && !reg_wr)
      begin
         rdata_next = BPE_RST_RDATA;
         unique case (reg_addr)
            BPE_OFS_PIN_SELECT: rdata_next[BPE_PIN_N-1:0]  = pin_enable_select;
            BPE_OFS_DVS_CONFIG: rdata_next[BPE_CFG_W-1:0]  = dvs_config_field;
            BPE_OFS_ALT_VOLT_0: rdata_next[BPE_CODE_W-1:0] = alt_voltage_code[0];
            BPE_OFS_ALT_VOLT_1: rdata_next[BPE_CODE_W-1:0] = alt_voltage_code[1];
            BPE_OFS_ALT_VOLT_2: rdata_next[BPE_CODE_W-1:0] = alt_voltage_code[2];
            BPE_OFS_ALT_VOLT_3: rdata_next[BPE_CODE_W-1:0] = alt_voltage_code[3];
            BPE_OFS_READBACK:   rdata_next[BPE_CODE_W-1:0] = readback_reg;
            default:            rdata_next = BPE_RST_RDATA;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         readback_reg <= BPE_RST_READBACK;
         rdata_reg    <= BPE_RST_RDATA;
         ack_reg      <= 1'b0;
         active_reg   <= 1'b0;
         pin_en_reg   <= 1'b0;
         target_reg   <= BPE_RST_ALT_VOLT;
      end
      else
      begin
         readback_reg <= readback_next;
         rdata_reg    <= rdata_next;
         ack_reg      <= ack_next;
         active_reg   <= active_next;
         pin_en_reg   <= pin_en_next;
         target_reg   <= target_next;
      end
   end

   assign reg_rdata            = rdata_reg;
   assign reg_ack              = ack_reg;
   assign pin_control_active   = active_reg;
   assign regulator_pin_enable = pin_en_reg;
   assign target_voltage_code  = target_reg;

endmodule : bpe_buck_ctrl

// ### design/bpe_pkg.sv
// Package holding register map, field widths and reset values for the buck pin and DVS block
package bpe_pkg;

   localparam int unsigned BPE_ADDR_W    = 8;
   localparam int unsigned BPE_DATA_W    = 8;
   localparam int unsigned BPE_CODE_W    = 6;
   localparam int unsigned BPE_CFG_W     = 5;
   localparam int unsigned BPE_PIN_N     = 6;
   localparam int unsigned BPE_SEQ_W     = 3;
   localparam int unsigned BPE_EN_W      = 2;
   localparam int unsigned BPE_ALT_N     = 4;

   localparam logic [7:0] BPE_OFS_PIN_SELECT   = 8'h39;
   localparam logic [7:0] BPE_OFS_DVS_CONFIG   = 8'h3A;
   localparam logic [7:0] BPE_OFS_ALT_VOLT_0   = 8'h3B;
   localparam logic [7:0] BPE_OFS_ALT_VOLT_1   = 8'h3C;
   localparam logic [7:0] BPE_OFS_ALT_VOLT_2   = 8'h3D;
   localparam logic [7:0] BPE_OFS_ALT_VOLT_3   = 8'h3E;
   localparam logic [7:0] BPE_OFS_READBACK     = 8'h3F;

   localparam logic [5:0] BPE_RST_PIN_SELECT   = 6'h00;
   localparam logic [4:0] BPE_RST_DVS_CONFIG   = 5'h00;
   localparam logic [5:0] BPE_RST_ALT_VOLT     = 6'h00;
   localparam logic [5:0] BPE_RST_READBACK     = 6'h00;
   localparam logic [7:0] BPE_RST_RDATA        = 8'h00;

   localparam logic [2:0] BPE_SEQ_BY_ENABLE    = 3'h7;
   localparam logic [1:0] BPE_EN_BY_PINS       = 2'h2;

endpackage : bpe_pkg

// ### design/bpe_field_reg.sv
// Writable register field of parameterised width with constant reset value
`timescale 1ns/1ps
module bpe_field_reg #(
   parameter int unsigned    W         = 6,
   parameter logic [W-1:0]   RST_VALUE = '0
) (
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic         wr_en,
   input  wire logic [W-1:0] wdata,
   output logic      [W-1:0] q
);

   logic [W-1:0] q_reg;
   logic [W-1:0] q_next;

   always_comb
   begin
      q_next = q_reg;
      if (wr_en)
      begin
         q_next = wdata;
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         q_reg <= RST_VALUE;
      end
      else
      begin
         q_reg <= q_next;
      end
   end

   assign q = q_reg;

endmodule : bpe_field_reg

// ### design/bpe_pin_enable.sv
// Gated OR of the selected multipurpose control pins
`timescale 1ns/1ps
module bpe_pin_enable
   import bpe_pkg::*;
(
   input  wire logic [BPE_PIN_N-1:0] pin_select,
   input  wire logic [BPE_PIN_N-1:0] pin_level,
   input  wire logic [BPE_SEQ_W-1:0] seq_field,
   input  wire logic [BPE_EN_W-1:0]  en_field,
   output logic                      active,
   output logic                      enable
);

   // Pin selections only count in the pin-controlled mode
   assign active = (seq_field == BPE_SEQ_BY_ENABLE) && (en_field == BPE_EN_BY_PINS);
   // A zero select bit masks its pin out of the OR
   assign enable = active && (|(pin_select & pin_level));

endmodule : bpe_pin_enable

// ### dv/bpe_chk_props.sv
// Checker of register handshake, readback and pin control timing
`timescale 1ns/1ps
module bpe_chk
   import bpe_pkg::*;
(
   input wire logic       mclk,
   input wire logic       rst,
   input wire logic [7:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       reg_ack,
   input wire logic [5:0] multipurpose_control_pin,
   input wire logic [1:0] dvs_pin_state,
   input wire logic [2:0] regulator_sequence_field,
   input wire logic [1:0] regulator_enable_field,
   input wire logic [5:0] serial_voltage_code,
   input wire logic       pin_control_active,
   input wire logic       regulator_pin_enable,
   input wire logic [5:0] target_voltage_code
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_rd_taken;
      reg_rd && !reg_wr;
   endsequence
   wire gate = (regulator_sequence_field == BPE_SEQ_BY_ENABLE) &&
               (regulator_enable_field == BPE_EN_BY_PINS);
   a_ack_after_req: assert property ((reg_wr || reg_rd) |=> reg_ack) else $error("ack missing");
   a_ack_no_req: assert property (!(reg_wr || reg_rd) |=> !reg_ack) else $error("stray ack");
   a_active_decode: assert property (gate |=> pin_control_active) else $error("not active");
   a_gate_blocks: assert property (!gate |=> !pin_control_active && !regulator_pin_enable)
      else $error("enable not gated");
   a_no_pin_off: assert property (multipurpose_control_pin == 6'h00 |=> !regulator_pin_enable)
      else $error("enable without pin");
   // Two quiet cycles cover the write path into the alternate code registers
   a_target_hold: assert property (!reg_wr && !$past(reg_wr) && $stable(dvs_pin_state)
      |=> $stable(target_voltage_code)) else $error("target moved");
   a_readback_code: assert property (s_rd_taken ##0 reg_addr == BPE_OFS_READBACK
      |=> reg_rdata == {2'h0, $past(serial_voltage_code, 2)}) else $error("bad readback");
   a_unmapped_zero: assert property (s_rd_taken ##0 !(reg_addr inside {[8'h39:8'h3F]})
      |=> reg_rdata == 8'h00) else $error("unmapped not zero");
   a_upper_zero: assert property (reg_ack |-> reg_rdata[7:6] == 2'h0) else $error("upper set");
   a_rdata_hold: assert property (!(reg_rd && !reg_wr) |=> $stable(reg_rdata))
      else $error("rdata moved");
endmodule : bpe_chk
bind bpe_buck_ctrl bpe_chk i_bpe_chk (.*);

// ### dv/bpe_pin_host.sv
// Host model driving control pin levels and the two-bit pin state
`timescale 1ns/1ps
module bpe_pin_host
(
   input  wire logic       mclk,
   output logic      [5:0] pins,
   output logic      [1:0] state
);
   // New levels every cycle, so pin states vary under every register setting
   always @(negedge mclk)
   begin
      pins  <= 6'($urandom);
      state <= 2'($urandom);
   end
endmodule : bpe_pin_host

// ### dv/testbench.sv
// Self-checking bench for the buck pin enable and voltage code register block
`timescale 1ns/1ps
module testbench
   import bpe_pkg::*;
;
   logic       mclk, rst, reg_wr, reg_rd, reg_ack, act, pen, x;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd, a, d;
   logic [7:0] model [8'h38:8'h40];
   logic [5:0] pins, serial, target, p;
   logic [4:0] cfg;
   logic [2:0] seq;
   logic [1:0] state, en, s;
   int         miscompares = 0, checks = 0;
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   bpe_buck_ctrl i_bpe_buck_ctrl (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_ack(reg_ack), .multipurpose_control_pin(pins), .dvs_pin_state(state),
      .regulator_sequence_field(seq), .regulator_enable_field(en),
      .serial_voltage_code(serial), .pin_control_active(act), .regulator_pin_enable(pen),
      .target_voltage_code(target), .dvs_config_field(cfg));
   bpe_pin_host i_bpe_pin_host (.mclk(mclk), .pins(pins), .state(state));
   function automatic logic [7:0] mask(input logic [7:0] adr, input logic [7:0] dat);
      if (adr == BPE_OFS_DVS_CONFIG)
         return dat & 8'h1F;
      if (adr >= BPE_OFS_PIN_SELECT && adr < BPE_OFS_READBACK)
         return dat & 8'h3F;
      return 8'h00;
   endfunction : mask
   task compare(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : compare
   task print_verdict;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict
   // One pulse per access, then a quiet cycle so no strobe is set twice in one step
   task access(input logic wr, input logic [7:0] adr, input logic [7:0] dat);
      {reg_wr, reg_rd, reg_addr, reg_wdata} = {wr, !wr, adr, dat};
      @(negedge mclk);
      {reg_wr, reg_rd} = 2'b00;
      rd = reg_rdata;
      compare({7'h00, reg_ack}, 8'h01);
      if (reg_ack !== 1'b1)
         print_verdict();
      @(negedge mclk);
   endtask : access
   initial
   begin
      void'($urandom(32'h0631));
      {rst, reg_wr, reg_rd, reg_addr, reg_wdata, seq, en, serial} = {1'b1, 29'h0};
      for (int i = 8'h38; i <= 8'h40; i++)
         model[i] = 8'h00;
      repeat (3) @(negedge mclk);
      rst = 1'b0;
      for (int i = 0; i < 9; i++)
      begin
         access(1'b0, 8'h38 + 8'(i), 8'h00);
         compare(rd, 8'h00);
      end
      for (int i = 0; i < 60; i++)
      begin
         a = (i < 9) ? 8'h38 + 8'(i) : 8'h38 + 8'($urandom % 9);
         d = (i < 9) ? 8'hFF : 8'($urandom);
         serial = 6'($urandom);
         access(1'b1, a, d);
         model[a] = mask(a, d);
         access(1'b0, a, 8'h00);
         compare(rd, (a == BPE_OFS_READBACK) ? {2'h0, serial} : model[a]);
      end
      compare({3'h0, cfg}, model[BPE_OFS_DVS_CONFIG]);
      // Write and read strobed together must act as a write and leave read data alone
      {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b11, BPE_OFS_ALT_VOLT_0, 8'hC5};
      @(negedge mclk);
      {reg_wr, reg_rd} = 2'b00;
      @(negedge mclk);
      model[BPE_OFS_ALT_VOLT_0] = mask(BPE_OFS_ALT_VOLT_0, 8'hC5);
      access(1'b0, BPE_OFS_ALT_VOLT_0, 8'h00);
      compare(rd, model[BPE_OFS_ALT_VOLT_0]);
      for (int k = 0; k < 240; k++)
      begin
         if (k % 60 == 0)
         begin
            d = (k == 0) ? 8'h3F : 8'($urandom);
            access(1'b1, BPE_OFS_PIN_SELECT, d);
            model[BPE_OFS_PIN_SELECT] = mask(BPE_OFS_PIN_SELECT, d);
         end
         seq = ($urandom % 2) ? BPE_SEQ_BY_ENABLE : 3'($urandom);
         en = ($urandom % 2) ? BPE_EN_BY_PINS : 2'($urandom);
         #1;
         p = pins;
         s = state;
         x = (seq == BPE_SEQ_BY_ENABLE) && (en == BPE_EN_BY_PINS);
         d = {x, x && |(model[BPE_OFS_PIN_SELECT][5:0] & p), model[8'h3B + 8'(s)][5:0]};
         @(negedge mclk);
         compare({act, pen, target}, d);
      end
      // Mid-run reset clears outputs and registers; first read right after release
      rst = 1'b1;
      @(negedge mclk);
      compare({act, pen, target}, 8'h00);
      rst = 1'b0;
      access(1'b0, BPE_OFS_DVS_CONFIG, 8'h00);
      compare(rd, 8'h00);
      compare({3'h0, cfg}, 8'h00);
      print_verdict();
   end
endmodule : testbench
